// *** bench/pet_rtc_model.sv ***
// Purpose: Clock source standing in for the calendar and scan logic.
// Assumes: Hour and minute start at zero on load.
// Notes: Tick and strobe share a phase to exercise coinciding events.
`timescale 1ns/1ps
module pet_rtc_model #(
  parameter int TICK = 4,
  parameter int SECS = 8
) (
  input  wire  pclk,
  input  wire  presetn,
  input  wire  load,
  input  wire  [5:0] ld_sec,
  output logic scan_tick,
  output logic sec_strobe,
  output logic [4:0] hour,
  output logic [5:0] min,
  output logic [5:0] sec
);
  int tc;
  int sc;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc <= 0;
      sc <= 0;
      {scan_tick, sec_strobe, hour, min, sec} <= '0;
    end else begin
      tc <= (tc == TICK-1) ? 0 : tc + 1;
      scan_tick <= (tc == TICK-1);
      sc <= (sc == SECS-1) ? 0 : sc + 1;
      sec_strobe <= (sc == SECS-1);
      if (load) begin
        {hour, min} <= '0;
        sec <= ld_sec;
      end else if (sc == SECS-1) begin
        sec <= (sec == 6'h3B) ? 6'h00 : sec + 6'h01;
        if (sec == 6'h3B) min <= min + 6'h01;
      end
    end
  end
endmodule

// *** bench/pet_timer_bench.sv ***
// Purpose: Self-checking bench of the periodic event timer.
// Assumes: Scan tick every 4 clocks, second every 8 clocks.
// Notes: Windows are sized so that exactly the expected pulses fall inside.
`timescale 1ns/1ps
`include "pet_map.vh"
module pet_timer_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0, timer_reset = 1, prev, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, scan_tick, sec_strobe, event_out, running;
  logic [4:0] mday = 1, mlen = 31, hour;
  logic [2:0] wday = 1;
  logic [5:0] ldsec = 0, min, sec;
  int error_cnt = 0, checks = 0, n;
  always #12.5 pclk = ~pclk;
  pet_rtc_model pet_rtc_model_inst (.pclk, .presetn, .load(ld), .ld_sec(ldsec), .scan_tick, .sec_strobe,
    .hour, .min, .sec);
  pet_timer pet_timer_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scan_tick, .sec_strobe, .rtc_month(4'h1), .rtc_mday(mday),
    .rtc_wday(wday), .rtc_hour(hour), .rtc_min(min), .rtc_sec(sec), .rtc_month_len(mlen),
    .timer_reset, .event_out, .running);
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      error_cnt++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task count_ev(input int clocks);
    n = 0;
    prev = event_out;
    repeat (clocks) begin
      @(posedge pclk);
      if (event_out === 1'b1 && prev !== 1'b1) n++;
      prev = event_out;
    end
  endtask
  task load(input logic [5:0] s);
    @(posedge pclk) {ld, ldsec} <= {1'b1, s};
    @(posedge pclk) ld <= 0;
  endtask
  task regs_test;
    apb(0, `PET_OFS_START, 0); check(rd, `PET_START_RESET, "start reset");
    apb(0, `PET_OFS_CYCLE, 0); check(rd, `PET_CYCLE_RESET, "cycle reset");
    apb(0, 12'h020, 0); check(rd, 32'h0000_0000, "unmapped read");
    check(er, 1, "unmapped error");
    apb(1, `PET_OFS_CYCLE, 32'h001F_3F3F);
    apb(0, `PET_OFS_CYCLE, 0); check(rd, 32'h0017_3B3B, "cycle clamp");
    $display("registers done");
  endtask
  task cal_case(input logic [2:0] m, input logic [5:0] day, input logic [4:0] md, input logic [2:0] wd,
                input logic [4:0] ml, input logic rst, input int exp);
    {mday, wday, mlen, timer_reset} <= {md, wd, ml, rst};
    apb(1, `PET_OFS_START, {2'b00, day, 24'h000005});
    apb(1, `PET_OFS_CTRL, {29'h0, m});
    load(6'h02);
    count_ev(48);
    check(n, exp, "calendar pulses");
    $display("calendar mode %0d done", m);
  endtask
  task rstcyc_test;
    apb(1, `PET_OFS_CYCLE, 32'h2);
    apb(1, `PET_OFS_CTRL, `PET_MODE_RSTCYC);
    @(posedge pclk) timer_reset <= 1;
    @(posedge pclk) timer_reset <= 0;
    count_ev(40);
    check(n, 3, "reset cycle pulses");
    check(running, 1, "reset cycle running");
    timer_reset <= 1;
    count_ev(40);
    check({running, n[3:0]}, 5'h00, "reset cycle stop");
    apb(0, `PET_OFS_STATUS, 0); check(rd, 32'h1 << `PET_ST_RESET_IN, "status held off");
    timer_reset <= 0;
    $display("reset cycle done");
  endtask
  task timecyc_test;
    apb(1, `PET_OFS_START, 32'h3);
    apb(1, `PET_OFS_CTRL, `PET_MODE_TIMECYC);
    load(6'h00);
    count_ev(64);
    check(n, 3, "time cycle pulses");
    check(running, 1, "time cycle running");
    $display("time cycle done");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    timer_reset <= 0;
    regs_test;
    cal_case(`PET_MODE_MONTHLY, 6'd40, 5'd30, 3'd1, 5'd30, 0, 1);
    apb(0, `PET_OFS_START, 0); check(rd[29:24], 6'd31, "day clamp");
    cal_case(`PET_MODE_WEEKLY, 6'd3, 5'd1, 3'd3, 5'd31, 0, 1);
    cal_case(`PET_MODE_WEEKLY, 6'd3, 5'd1, 3'd4, 5'd31, 0, 0);
    cal_case(`PET_MODE_DAILY, 6'd0, 5'd9, 3'd2, 5'd31, 0, 1);
    cal_case(`PET_MODE_DAILY, 6'd0, 5'd9, 3'd2, 5'd31, 1, 0);
    timer_reset <= 0;
    rstcyc_test;
    timecyc_test;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
endmodule

// *** bench/pet_timer_checker.sv ***
// Purpose: Port-level checks of the periodic event timer.
// Assumes: clk_en high throughout; mode followed from CTRL writes.
// Notes: Bound to every pet_timer instance.
`timescale 1ns/1ps
`include "pet_map.vh"
module pet_timer_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scan_tick,
  input wire        sec_strobe,
  input wire        timer_reset,
  input wire        event_out,
  input wire        running
);
  reg [2:0] mode;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) mode <= 3'(`PET_CTRL_RESET);
    else if (psel && penable && pready && pwrite && paddr == `PET_OFS_CTRL) mode <= pwdata[2:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  AST_PREADY_AFTER_SETUP: assert property (setup_s |=> access_s) else $error("no ready after setup");
  AST_PREADY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("stray ready");
  AST_UNMAPPED_ERR: assert property (pready && paddr > `PET_OFS_ELAPSED |-> pslverr) else $error("no slave error");
  AST_PRDATA_IDLE: assert property (!psel && !$past(psel) |-> prdata == 32'h0) else $error("read data idle");
  AST_RISE_ON_TICK: assert property ($rose(event_out) |-> $past(scan_tick)) else $error("event off tick");
  AST_FALL_ON_TICK: assert property ($fell(event_out) |-> $past(scan_tick) || $past(timer_reset)) else $error("event length");
  AST_RESET_CLEARS: assert property (timer_reset |=> !event_out && !running) else $error("reset ignored");
  AST_RSTCYC_START: assert property (mode == `PET_MODE_RSTCYC && $fell(timer_reset) |=> running ##[0:6] event_out)
    else $error("reset cycle start");
  AST_RUN_MODE: assert property (running |-> mode == `PET_MODE_TIMECYC || mode == `PET_MODE_RSTCYC)
    else $error("running in calendar mode");
endmodule
bind pet_timer pet_timer_checker pet_timer_checker_inst (.*);

// *** logic/pet_elapsed.v ***
// Purpose: Counts whole seconds of a running cycle and reloads at the programmed interval.
// Assumes: sec_strobe is one clock wide, once per second, synchronous to pclk.
// Notes: A zero interval never reloads, so such a cycle gives only its start pulse.
`timescale 1ns/1ps
module pet_elapsed #(
  parameter W = 17
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire         restart,
  input  wire         run,
  input  wire         sec_strobe,
  input  wire [W-1:0] interval,
  output reg          reload,
  output reg  [W-1:0] count
);

  wire [W-1:0] count_inc;
  assign count_inc = count + {{(W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= {W{1'b0}};
      reload <= 1'b0;
    end else if (ce) begin
      reload <= 1'b0;
      if (restart || !run) begin
        count <= {W{1'b0}};
      end else if (sec_strobe) begin
        if (interval != {W{1'b0}} && count_inc >= interval) begin
          count  <= {W{1'b0}};
          reload <= 1'b1;
        end else begin
          count <= count_inc;
        end
      end
    end
  end

endmodule

// *** logic/pet_timer.v ***
// Purpose: Periodic event timer; monthly, weekly, daily and two repeating cycle modes.
// Assumes: All inputs synchronous to pclk; scan_tick and sec_strobe are one clock wide.
// Notes: Registers over APB; event_out stands from one scan tick to the next.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pet_map.vh"
module pet_timer (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   clk_en,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`PET_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire                   scan_tick,
  input  wire                   sec_strobe,
  input  wire [3:0]             rtc_month,
  input  wire [4:0]             rtc_mday,
  input  wire [2:0]             rtc_wday,
  input  wire [4:0]             rtc_hour,
  input  wire [5:0]             rtc_min,
  input  wire [5:0]             rtc_sec,
  input  wire [4:0]             rtc_month_len,
  input  wire                   timer_reset,
  output reg                    event_out,
  output reg                    running
);

  // Power-up field values, sliced from the full reset words so no bits are dropped
  localparam [31:0] CTRL_RST  = `PET_CTRL_RESET;
  localparam [31:0] START_RST = `PET_START_RESET;
  localparam [31:0] CYCLE_RST = `PET_CYCLE_RESET;

  // Control and settings
  reg  [2:0]  mode;
  reg  [5:0]  start_sec;
  reg  [5:0]  start_min;
  reg  [4:0]  start_hour;
  reg  [5:0]  start_day;
  reg  [5:0]  cyc_sec;
  reg  [5:0]  cyc_min;
  reg  [4:0]  cyc_hour;

  // Timing state
  reg         pending;
  reg         match_prev;
  reg         reset_prev;
  reg         restart;

  wire [`PET_SECS_W-1:0] interval;
  wire [`PET_SECS_W-1:0] elapsed;
  wire                   reload;

  // Interval in seconds from hour, minute, second fields
  function [`PET_SECS_W-1:0] hms_to_secs;
    input [4:0] h;
    input [5:0] m;
    input [5:0] s;
    begin
      hms_to_secs = {12'h000, h} * `PET_SECS_PER_HOUR
                  + {11'h000, m} * `PET_SECS_PER_MIN
                  + {11'h000, s};
    end
  endfunction

  // Field range limits; out-of-range writes are held at the top of the range
  function [5:0] clamp6;
    input [5:0] v;
    input [5:0] top;
    begin
      clamp6 = (v > top) ? top : v;
    end
  endfunction

  function [4:0] clamp_hour;
    input [4:0] v;
    begin
      clamp_hour = (v > 5'h17) ? 5'h17 : v;
    end
  endfunction

  assign interval = hms_to_secs(cyc_hour, cyc_min, cyc_sec);

  // Calendar compare
  wire        is_cycle_mode;
  wire [4:0]  eff_day;
  wire        hms_match;
  reg         day_match;
  wire        match;
  wire        match_edge;
  wire        reset_fall;

  assign is_cycle_mode = (mode == `PET_MODE_TIMECYC) || (mode == `PET_MODE_RSTCYC);

  // Start day above 31 already folds to 31 on write; short months fall to their last day
  assign eff_day = (start_day[4:0] > rtc_month_len) ? rtc_month_len : start_day[4:0];

  assign hms_match = ({rtc_hour, rtc_min, rtc_sec} == {start_hour, start_min, start_sec});

  always @* begin
    case (mode)
      `PET_MODE_MONTHLY: day_match = (rtc_mday == eff_day);
      `PET_MODE_WEEKLY:  day_match = ({3'h0, rtc_wday} == start_day);
      `PET_MODE_DAILY:   day_match = 1'b1;
      `PET_MODE_TIMECYC: day_match = 1'b1;
      default:           day_match = 1'b0;
    endcase
  end

  // Only the first clock of a matching second counts, so a set time fires once
  assign match      = hms_match && day_match;
  assign match_edge = match && !match_prev;
  assign reset_fall = reset_prev && !timer_reset;

  // Events that request a pulse in this clock
  reg  calendar_hit;
  reg  cycle_start;
  reg  set_now;

  always @* begin
    calendar_hit = 1'b0;
    cycle_start  = 1'b0;
    if (!timer_reset) begin
      case (mode)
        `PET_MODE_MONTHLY,
        `PET_MODE_WEEKLY,
        `PET_MODE_DAILY: calendar_hit = match_edge;
        `PET_MODE_TIMECYC: cycle_start = match_edge && !running;
        `PET_MODE_RSTCYC: cycle_start = reset_fall;
        default: cycle_start = 1'b0;
      endcase
    end
    set_now = calendar_hit || cycle_start || (reload && running && !timer_reset);
  end

  // Restart lands one clock after the start, so a strobe on the start clock is not counted
  pet_elapsed #(
    .W (`PET_SECS_W)
  ) u_elapsed (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (clk_en),
    .restart    (restart),
    .run        (running),
    .sec_strobe (sec_strobe),
    .interval   (interval),
    .reload     (reload),
    .count      (elapsed)
  );

  // APB decode
  wire        setup_phase;
  wire        wr_commit;
  reg         addr_ok;
  reg  [31:0] rd_value;

  assign setup_phase = psel && !penable;
  // Writes land on the access edge only, never on setup
  assign wr_commit   = psel && penable && pready && pwrite;

  // Fields read back clamped, so software sees the values the timer really uses
  always @* begin
    addr_ok  = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      `PET_OFS_CTRL: rd_value[`PET_CTRL_MODE_MSB:`PET_CTRL_MODE_LSB] = mode;
      `PET_OFS_START: begin
        rd_value[`PET_SEC_MSB:`PET_SEC_LSB]   = start_sec;
        rd_value[`PET_MIN_MSB:`PET_MIN_LSB]   = start_min;
        rd_value[`PET_HOUR_MSB:`PET_HOUR_LSB] = start_hour;
        rd_value[`PET_DAY_MSB:`PET_DAY_LSB]   = start_day;
      end
      `PET_OFS_CYCLE: begin
        rd_value[`PET_SEC_MSB:`PET_SEC_LSB]   = cyc_sec;
        rd_value[`PET_MIN_MSB:`PET_MIN_LSB]   = cyc_min;
        rd_value[`PET_HOUR_MSB:`PET_HOUR_LSB] = cyc_hour;
      end
      `PET_OFS_STATUS: begin
        rd_value[`PET_ST_RUNNING]  = running;
        rd_value[`PET_ST_EVENT]    = event_out;
        rd_value[`PET_ST_RESET_IN] = timer_reset;
        rd_value[`PET_ST_PENDING]  = pending;
      end
      `PET_OFS_ELAPSED: rd_value[`PET_SECS_W-1:0] = elapsed;
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer in the first access cycle; read data is captured at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_ok;
      if (setup_phase && !pwrite) begin
        prdata <= rd_value;
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Settings
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode       <= CTRL_RST[`PET_CTRL_MODE_MSB:`PET_CTRL_MODE_LSB];
      start_sec  <= START_RST[`PET_SEC_MSB:`PET_SEC_LSB];
      start_min  <= START_RST[`PET_MIN_MSB:`PET_MIN_LSB];
      start_hour <= START_RST[`PET_HOUR_MSB:`PET_HOUR_LSB];
      start_day  <= START_RST[`PET_DAY_MSB:`PET_DAY_LSB];
      cyc_sec    <= CYCLE_RST[`PET_SEC_MSB:`PET_SEC_LSB];
      cyc_min    <= CYCLE_RST[`PET_MIN_MSB:`PET_MIN_LSB];
      cyc_hour   <= CYCLE_RST[`PET_HOUR_MSB:`PET_HOUR_LSB];
    end else if (clk_en && wr_commit) begin
      case (paddr)
        `PET_OFS_CTRL: mode <= pwdata[`PET_CTRL_MODE_MSB:`PET_CTRL_MODE_LSB];
        `PET_OFS_START: begin
          start_sec  <= clamp6(pwdata[`PET_SEC_MSB:`PET_SEC_LSB], 6'h3B);
          start_min  <= clamp6(pwdata[`PET_MIN_MSB:`PET_MIN_LSB], 6'h3B);
          start_hour <= clamp_hour(pwdata[`PET_HOUR_MSB:`PET_HOUR_LSB]);
          start_day  <= clamp6(pwdata[`PET_DAY_MSB:`PET_DAY_LSB], `PET_DAY_MAX);
        end
        `PET_OFS_CYCLE: begin
          cyc_sec  <= clamp6(pwdata[`PET_SEC_MSB:`PET_SEC_LSB], 6'h3B);
          cyc_min  <= clamp6(pwdata[`PET_MIN_MSB:`PET_MIN_LSB], 6'h3B);
          cyc_hour <= clamp_hour(pwdata[`PET_HOUR_MSB:`PET_HOUR_LSB]);
        end
        default: mode <= mode;
      endcase
    end
  end

  wire mode_write;
  assign mode_write = wr_commit && (paddr == `PET_OFS_CTRL);

  // Cycle run state and edge history
  // Edge history resets low, so a reset input already low at power-up is not taken as a fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running    <= 1'b0;
      restart    <= 1'b0;
      match_prev <= 1'b0;
      reset_prev <= 1'b0;
    end else if (clk_en) begin
      match_prev <= match;
      reset_prev <= timer_reset;
      restart    <= cycle_start;
      if (timer_reset || mode_write || !is_cycle_mode) begin
        running <= 1'b0;
      end else if (cycle_start) begin
        running <= 1'b1;
      end
    end
  end

  // Pulse held for one scan cycle; a request landing on a tick goes out at once
  // Reset high drops the pulse at once rather than waiting for the next scan tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending   <= 1'b0;
      event_out <= 1'b0;
    end else if (clk_en) begin
      if (timer_reset) begin
        pending   <= 1'b0;
        event_out <= 1'b0;
      end else if (scan_tick) begin
        event_out <= pending || set_now;
        pending   <= 1'b0;
      end else if (set_now) begin
        pending <= 1'b1;
      end
    end
  end

endmodule

// *** pkg/pet_map.vh ***
// Purpose: Register map, field layout, reset values and mode codes of the periodic event timer.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Included by the timer, its checker and its bench.
//
// Overview of operation
// - Event output is high for exactly one scan cycle per reached set time.
// - Reset input high disables the event output; low enables it.
// - Start day, hour, minute and second settings are compared with the real-time clock.
// - Monthly mode pulses once a month at start day, hour, minute, second.
// - Monthly start day above 31 is 31; short months pulse on their last day.
// - Weekly mode pulses once a week on start weekday at start time.
// - Daily mode pulses once a day at the start hour, minute, second.
// - Time cycle mode starts at start time, then pulses every cycle interval.
// - Once a time cycle runs, start time is ignored until reset goes high.
// - Time cycle: reset high stops cycle and holds start; low arms start compare.
// - Reset cycle mode starts timing on the reset input falling edge.
// - Reset cycle mode also pulses one scan cycle at that falling edge.
// - Reset cycle repeats until reset goes high, which stops it.
// - Interval and start time take hours 0-23, minutes 0-59, seconds 0-59.
`ifndef PET_MAP_VH
`define PET_MAP_VH

`define PET_ADDR_W        12
`define PET_OFS_CTRL      12'h000
`define PET_OFS_START     12'h004
`define PET_OFS_CYCLE     12'h008
`define PET_OFS_STATUS    12'h00C
`define PET_OFS_ELAPSED   12'h010

`define PET_CTRL_MODE_LSB 0
`define PET_CTRL_MODE_MSB 2
`define PET_CTRL_RESET    32'h0000_0002

`define PET_SEC_LSB       0
`define PET_SEC_MSB       5
`define PET_MIN_LSB       8
`define PET_MIN_MSB       13
`define PET_HOUR_LSB      16
`define PET_HOUR_MSB      20
`define PET_DAY_LSB       24
`define PET_DAY_MSB       29
`define PET_START_RESET   32'h0100_0000
`define PET_CYCLE_RESET   32'h0000_0000

`define PET_ST_RUNNING    0
`define PET_ST_EVENT      1
`define PET_ST_RESET_IN   2
`define PET_ST_PENDING    3

`define PET_MODE_MONTHLY  3'h0
`define PET_MODE_WEEKLY   3'h1
`define PET_MODE_DAILY    3'h2
`define PET_MODE_TIMECYC  3'h3
`define PET_MODE_RSTCYC   3'h4

`define PET_DAY_MAX       6'h1F
`define PET_SECS_PER_MIN  17'h0003C
`define PET_SECS_PER_HOUR 17'h00E10
`define PET_SECS_W        17

`endif
